// ### sts_sequencer.v
// Purpose: Sweep sequencing: mode, trigger, dwell, points, abort, manual
// Assumes: APB register access, 10 MHz ref_clk, rear trigger async
// Notes:   Sweep and dwell durations are 1-2-5 ladder indices
//
// Functional notes
// - Time key in analog mode makes forward sweep duration the active parameter.
// - Time key in stepped mode makes per-point dwell the active parameter.
// - Time key cancels manual sweep; it is the only exit from manual.
// - Keep entered time unless auto time is set; use larger of it and range minimum, always.
// - Durations step only through a 1-2-5 decade ladder.
// - Sweep indicator lit only while a sweep is really running.
// - Auto time sets time to the minimum; otherwise time stays.
// - Manual mode lights the manual indicator.
// - Manual mode overrides analog or stepped generation.
// - Trigger key and mode key advance their selections cyclically.
// - Continuous trigger restarts a sweep right after the last one.
// - External mode: rising rear edge starts sweep after about 1 ms.
// - Whole-sweep external trigger inert while stepped external is selected.
// - Single mode: one sweep per single key or initiate command.
// - Abort stops any sweep at once and returns to start.
// - Stepped continuous: dwell each point, step at once, light step indicator.
// - Stepped external: after dwell, step on rear rising edge, about 2 ms later.
// - Stepped sweep refused with alternate sweep or whole-sweep external trigger.
// - Single key triggers a sweep and forces single trigger mode.
// - Point count accepts only 2 through 1601.
// - Stepped sweep lasts points times the sum of dwell and switching time.
`timescale 1ns/1ns
`default_nettype none
`include "sts_regs.vh"

module sts_sequencer #(
  parameter PT_W        = 11,
  parameter EXT_LAT_CYC = (`STS_EXT_LAT_US * (`STS_CLK_KHZ / 1000)),
  parameter STP_LAT_CYC = (`STS_STEP_LAT_US * (`STS_CLK_KHZ / 1000)),
  parameter SWITCH_CYC  = (`STS_SWITCH_US * (`STS_CLK_KHZ / 1000)),
  parameter RETR_CYC    = (`STS_RETRACE_US * (`STS_CLK_KHZ / 1000)),
  parameter CYC_PER_MS  = `STS_CLK_KHZ
) (
  input  wire            ref_clk,
  input  wire            rst_n,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire            ext_trig_in,
  output reg             sweep_active,
  output reg             step_indicator,
  output reg             manual_sweep_indicator,
  output reg  [PT_W-1:0] point_index,
  output reg             retrace,
  output reg  [1:0]      active_param
);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_DELAY = 5'h02;
  localparam [4:0] S_RUN   = 5'h04;
  localparam [4:0] S_WAIT  = 5'h08;
  localparam [4:0] S_RETR  = 5'h10;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [1:0]      trig_mode;
  reg [1:0]      gen_mode;
  reg            auto_time;
  reg            alt_sweep;
  reg            manual_on;
  reg [4:0]      time_entered;
  reg [4:0]      dwell_entered;
  reg [4:0]      min_idx;
  reg [PT_W-1:0] points;
  reg [4:0]      state;
  reg [31:0]     cnt;
  reg [2:0]      trig_sync;
  reg            trig_level;
  reg            ext_pending;
  reg            single_pend;

  wire       wr_en = psel & penable & pwrite;
  wire       rd_en = psel & penable & ~pwrite;
  wire       cmd_wr = wr_en && (paddr == `STS_CMD_OFS);
  wire       time_key = cmd_wr & pwdata[`STS_CMD_TIME_KEY];
  wire       man_key = cmd_wr & pwdata[`STS_CMD_MANUAL];
  wire       trig_key = cmd_wr & pwdata[`STS_CMD_TRIG_KEY];
  wire       mode_key = cmd_wr & pwdata[`STS_CMD_MODE_KEY];
  wire       single_key = cmd_wr & pwdata[`STS_CMD_SINGLE_KEY];
  wire       init_cmd = cmd_wr & pwdata[`STS_CMD_INIT];
  wire       abort_cmd = cmd_wr & pwdata[`STS_CMD_ABORT];
  wire       single_req = single_key | (init_cmd & (trig_mode == `STS_TRIG_SINGLE));

  // Effective durations: larger of entered value and range minimum
  wire [4:0] time_eff = (time_entered < min_idx) ? min_idx : time_entered;
  wire [4:0] dwell_eff = (dwell_entered < min_idx) ? min_idx : dwell_entered;
  wire       stepped = (gen_mode != `STS_GEN_ANALOG) & ~manual_on;
  wire [4:0] ladder_idx = stepped ? dwell_eff : time_eff;
  wire [31:0] dur_cyc;

  sts_time_ladder #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_ladder (
    .idx    (ladder_idx),
    .cycles (dur_cyc)
  );

  // ----------------------------------------------------------------
  // Rear trigger synchroniser and edge detect
  // ----------------------------------------------------------------
  wire trig_rise = (trig_sync[2] == trig_sync[1]) & trig_sync[1] & ~trig_level;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync  <= 3'h0;
      trig_level <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[1:0], ext_trig_in};
      if (trig_sync[2] == trig_sync[1])
        trig_level <= trig_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Configuration and key handling
  // ----------------------------------------------------------------
  reg [1:0] next_gen;
  always @* begin
    next_gen = gen_mode + 2'h1;
    if (next_gen > `STS_GEN_STEP_EXT)
      next_gen = `STS_GEN_ANALOG;
    // Stepped generation is skipped when it cannot be used
    if (alt_sweep || trig_mode == `STS_TRIG_EXT)
      next_gen = `STS_GEN_ANALOG;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_mode     <= `STS_TRIG_CONT;
      gen_mode      <= `STS_GEN_ANALOG;
      auto_time     <= 1'b0;
      alt_sweep     <= 1'b0;
      manual_on     <= 1'b0;
      time_entered  <= `STS_TIME_RST;
      dwell_entered <= `STS_DWELL_RST;
      min_idx       <= 5'h0;
      points        <= `STS_POINTS_RST;
      active_param  <= `STS_ACT_NONE;
    end else begin
      if (wr_en && paddr == `STS_CTRL_OFS) begin
        trig_mode <= (pwdata[`STS_CTRL_TRIG_LSB +: 2] > `STS_TRIG_SINGLE) ?
                     trig_mode : pwdata[`STS_CTRL_TRIG_LSB +: 2];
        auto_time <= pwdata[`STS_CTRL_AUTO_BIT];
        alt_sweep <= pwdata[`STS_CTRL_ALT_BIT];
        // Stepped with alternate or external trigger is refused
        if (pwdata[`STS_CTRL_GEN_LSB +: 2] <= `STS_GEN_STEP_EXT &&
            (pwdata[`STS_CTRL_GEN_LSB +: 2] == `STS_GEN_ANALOG ||
             (!pwdata[`STS_CTRL_ALT_BIT] &&
              pwdata[`STS_CTRL_TRIG_LSB +: 2] != `STS_TRIG_EXT)))
          gen_mode <= pwdata[`STS_CTRL_GEN_LSB +: 2];
      end
      if (wr_en && paddr == `STS_TIME_OFS)
        time_entered <= pwdata[4:0];
      if (wr_en && paddr == `STS_DWELL_OFS)
        dwell_entered <= pwdata[4:0];
      if (wr_en && paddr == `STS_MINIDX_OFS)
        min_idx <= pwdata[4:0];
      // Out-of-range point counts are ignored
      if (wr_en && paddr == `STS_POINTS_OFS &&
          pwdata[31:PT_W] == 0 &&
          pwdata[PT_W-1:0] >= `STS_POINTS_MIN &&
          pwdata[PT_W-1:0] <= `STS_POINTS_MAX)
        points <= pwdata[PT_W-1:0];
      // Auto time pins the entered time to the minimum
      if (auto_time) begin
        time_entered  <= min_idx;
        dwell_entered <= min_idx;
      end
      if (trig_key)
        trig_mode <= (trig_mode == `STS_TRIG_SINGLE) ? `STS_TRIG_CONT :
                     trig_mode + 2'h1;
      if (mode_key)
        gen_mode <= next_gen;
      if (single_key)
        trig_mode <= `STS_TRIG_SINGLE;
      if (man_key) begin
        manual_on    <= 1'b1;
        active_param <= `STS_ACT_MANUAL;
      end
      if (time_key) begin
        manual_on    <= 1'b0;
        active_param <= (gen_mode == `STS_GEN_ANALOG) ? `STS_ACT_SWEEP :
                        `STS_ACT_DWELL;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sweep sequencer
  // ----------------------------------------------------------------
  wire ext_whole = (trig_mode == `STS_TRIG_EXT) &
                   (gen_mode != `STS_GEN_STEP_EXT);
  wire start_req = (trig_mode == `STS_TRIG_CONT) | single_pend |
                   (ext_whole & trig_rise);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                  <= S_IDLE;
      cnt                    <= 32'h0;
      point_index            <= {PT_W{1'b0}};
      ext_pending            <= 1'b0;
      single_pend            <= 1'b0;
      sweep_active           <= 1'b0;
      step_indicator         <= 1'b0;
      manual_sweep_indicator <= 1'b0;
      retrace                <= 1'b0;
    end else begin
      manual_sweep_indicator <= manual_on;
      step_indicator <= stepped;
      if (single_req)
        single_pend <= 1'b1;
      if (abort_cmd || manual_on) begin
        // Manual overrides generation; abort resets to start
        state        <= S_IDLE;
        cnt          <= 32'h0;
        point_index  <= {PT_W{1'b0}};
        sweep_active <= 1'b0;
        retrace      <= 1'b0;
        ext_pending  <= 1'b0;
        if (abort_cmd)
          single_pend <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            if (start_req) begin
              single_pend <= single_req;  // A new request in this cycle is kept
              cnt         <= 32'h0;
              if (ext_whole && !(trig_mode == `STS_TRIG_SINGLE) && !single_pend)
                state <= S_DELAY;
              else begin
                state        <= S_RUN;
                sweep_active <= 1'b1;
              end
            end
          end
          S_DELAY: begin
            if (cnt >= EXT_LAT_CYC - 1) begin
              cnt          <= 32'h0;
              state        <= S_RUN;
              sweep_active <= 1'b1;
            end else
              cnt <= cnt + 32'h1;
          end
          S_RUN: begin
            // Dwell per point, or forward sweep in analog mode
            if (cnt >= dur_cyc + (stepped ? SWITCH_CYC : 0) - 1) begin
              cnt <= 32'h0;
              if (!stepped || point_index == points - 1'b1) begin
                point_index  <= {PT_W{1'b0}};
                sweep_active <= 1'b0;
                retrace      <= 1'b1;
                state        <= S_RETR;
              end else if (gen_mode == `STS_GEN_STEP_EXT) begin
                ext_pending <= 1'b0;
                state       <= S_WAIT;
              end else
                point_index <= point_index + 1'b1;
            end else
              cnt <= cnt + 32'h1;
          end
          S_WAIT: begin
            if (trig_rise)
              ext_pending <= 1'b1;
            if (ext_pending) begin
              if (cnt >= STP_LAT_CYC - 1) begin
                cnt         <= 32'h0;
                ext_pending <= 1'b0;
                point_index <= point_index + 1'b1;
                state       <= S_RUN;
              end else
                cnt <= cnt + 32'h1;
            end
          end
          S_RETR: begin
            if (cnt >= RETR_CYC - 1) begin
              cnt     <= 32'h0;
              retrace <= 1'b0;
              state   <= S_IDLE;
            end else
              cnt <= cnt + 32'h1;
          end
          default: begin
            state <= S_IDLE;
            cnt   <= 32'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  reg [31:0] next_rdata;
  reg        next_err;
  always @* begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (paddr)
      `STS_CTRL_OFS:   next_rdata = {26'h0, alt_sweep, auto_time, gen_mode, trig_mode};
      `STS_CMD_OFS:    next_rdata = 32'h0;
      `STS_TIME_OFS:   next_rdata = {27'h0, time_eff};
      `STS_DWELL_OFS:  next_rdata = {27'h0, dwell_eff};
      `STS_POINTS_OFS: next_rdata = {{(32-PT_W){1'b0}}, points};
      `STS_MINIDX_OFS: next_rdata = {27'h0, min_idx};
      `STS_STATUS_OFS: next_rdata = {16'h0, active_param, manual_on, retrace,
                                     state[3:0], 6'h0,
                                     sweep_active, step_indicator};
      `STS_SWTIME_OFS: next_rdata = dur_cyc;
      default:         next_err   = 1'b1;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      if (psel && !penable && !pwrite)
        prdata <= next_rdata;
    end
  end

endmodule // sts_sequencer

`default_nettype wire

// ### sts_regs.vh
// Purpose: Register map and constants of the sweep trigger sequencer
// Assumes: APB slave, 32-bit data, 10 MHz reference clock
// Notes:   Offsets are byte addresses
`ifndef STS_REGS_VH
`define STS_REGS_VH

`define STS_CTRL_OFS       12'h000
`define STS_CMD_OFS        12'h004
`define STS_TIME_OFS       12'h008
`define STS_DWELL_OFS      12'h00c
`define STS_POINTS_OFS     12'h010
`define STS_MINIDX_OFS     12'h014
`define STS_STATUS_OFS     12'h018
`define STS_SWTIME_OFS     12'h01c

// Control fields
`define STS_CTRL_TRIG_LSB  0
`define STS_CTRL_GEN_LSB   2
`define STS_CTRL_AUTO_BIT  4
`define STS_CTRL_ALT_BIT   5

// Command bits (write one to act)
`define STS_CMD_TIME_KEY   0
`define STS_CMD_MANUAL     1
`define STS_CMD_TRIG_KEY   2
`define STS_CMD_MODE_KEY   3
`define STS_CMD_SINGLE_KEY 4
`define STS_CMD_INIT       5
`define STS_CMD_ABORT      6

// Trigger modes
`define STS_TRIG_CONT      2'h0
`define STS_TRIG_EXT       2'h1
`define STS_TRIG_SINGLE    2'h2
// Sweep generation
`define STS_GEN_ANALOG     2'h0
`define STS_GEN_STEP_CONT  2'h1
`define STS_GEN_STEP_EXT   2'h2

// Active parameter codes
`define STS_ACT_NONE       2'h0
`define STS_ACT_SWEEP      2'h1
`define STS_ACT_DWELL      2'h2
`define STS_ACT_MANUAL     2'h3

// Reset values and point count limits
`define STS_TIME_RST       5'h03
`define STS_DWELL_RST      5'h03
`define STS_POINTS_RST     11'h065
`define STS_POINTS_MIN     11'h002
`define STS_POINTS_MAX     11'h641

// Clock in kHz; timing in microseconds
`define STS_CLK_KHZ        10000
`define STS_EXT_LAT_US     1000
`define STS_STEP_LAT_US    2000
`define STS_SWITCH_US      7000
`define STS_RETRACE_US     1000

`endif

// ### sts_time_ladder.v
// Purpose: Converts a 1-2-5 ladder index into a duration in clock cycles
// Assumes: Index 0 is 1 ms; each step goes 1, 2, 5 per decade
// Notes:   Pure combinational lookup
`timescale 1ns/1ns
`default_nettype none

module sts_time_ladder #(
  parameter CYC_PER_MS = 10000
) (
  input  wire [4:0]  idx,
  output reg  [31:0] cycles
);

  reg [31:0] ms;
  reg [31:0] dec;
  integer    k;

  // Each index maps to one of 1/2/5 times a power of ten in ms
  always @* begin
    dec = 32'h1;
    for (k = 0; k < 10; k = k + 1) begin
      if (k < idx / 3)
        dec = dec * 32'd10;
    end
    case (idx % 3)
      0:       ms = dec;
      1:       ms = dec * 32'd2;
      default: ms = dec * 32'd5;
    endcase
    cycles = ms * CYC_PER_MS;
  end

endmodule // sts_time_ladder

`default_nettype wire

// ### sts_seq_sva.sv
// Purpose: Port-level assertions for the sweep trigger sequencer
// Assumes: One clock domain, zero-wait APB answers
// Notes:   Bound into every sts_sequencer instance
`timescale 1ns/1ns
`default_nettype none
module sts_seq_sva #(
  parameter PT_W     = 11,
  parameter RETR_CYC = 10000
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            sweep_active,
  input wire logic            step_indicator,
  input wire logic            manual_sweep_indicator,
  input wire logic [PT_W-1:0] point_index,
  input wire logic            retrace
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // -----------------------------------------
  // Retrace length counter
  // -----------------------------------------
  logic [15:0] rcnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      rcnt <= 16'h0000;
    else
      rcnt <= retrace ? rcnt + 16'h0001 : 16'h0000;
  end
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_retrace_quiet: assert property (retrace |-> !sweep_active)
    else $error("sweep shown during retrace");
  chk_retrace_len: assert property (retrace |-> rcnt < RETR_CYC)
    else $error("retrace too long");
  chk_index_home: assert property (retrace && $past(retrace) |-> point_index == 0)
    else $error("index not home in retrace");
  chk_index_range: assert property (point_index < 1601)
    else $error("index beyond last point");
  chk_manual_idle: assert property (manual_sweep_indicator [*3] |-> !sweep_active)
    else $error("sweep runs in manual mode");
  chk_step_manual: assert property (step_indicator && $past(step_indicator)
    |-> !manual_sweep_indicator)
    else $error("step lit in manual mode");
  cov_sweep: cover property ($rose(sweep_active));
  cov_retrace: cover property ($fell(retrace));
  cov_slverr: cover property (pready && pslverr);
endmodule // sts_seq_sva
bind sts_sequencer sts_seq_sva #(.PT_W(PT_W), .RETR_CYC(RETR_CYC)) sts_seq_sva_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .sweep_active(sweep_active), .step_indicator(step_indicator),
  .manual_sweep_indicator(manual_sweep_indicator), .point_index(point_index),
  .retrace(retrace));
`default_nettype wire

// ### sts_trig_src.sv
// Purpose: Rear trigger source feeding the external trigger input
// Assumes: Logic-level pulses launched just after rising clock edges
// Notes:   Line rests low between pulses
`timescale 1ns/1ns
`default_nettype none
module sts_trig_src (
  input  wire logic ref_clk,
  output var  logic ext_trig_in
);
  initial ext_trig_in = 1'b0;
  task automatic fire(input int hi);
    @(posedge ref_clk);
    ext_trig_in <= 1'b1; // Clean rising edge
    repeat (hi) @(posedge ref_clk);
    ext_trig_in <= 1'b0;
  endtask
endmodule // sts_trig_src
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for the sweep trigger sequencer
// Assumes: Shortened latencies, two cycles per millisecond
// Notes:   Registers reached through APB tasks only
`timescale 1ns/1ns
`default_nettype none
`include "sts_regs.vh"
module testbench;
  localparam int CPM = 2;
  localparam int EXT_LAT = 8;
  localparam int STP_LAT = 12;
  localparam int SW_CYC = 6;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_trig_in;
  logic        sweep_active;
  logic        step_indicator;
  logic        manual_sweep_indicator;
  logic [10:0] point_index;
  logic [10:0] pmax = 11'h000;
  logic [10:0] p;
  logic        retrace;
  logic [1:0]  active_param;
  logic        sa_q = 1'b0;
  logic [31:0] rdat;
  logic        rerr;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int rises = 0;
  int n;
  int r;
  int len;
  int c0;
  int pw[5] = '{1, 2, 1601, 1602, 0};
  int pe[5] = '{101, 2, 1601, 1601, 1601};
  int te[3] = '{1, 2, 0};
  always #50 ref_clk = ~ref_clk;
  sts_sequencer #(.EXT_LAT_CYC(EXT_LAT), .STP_LAT_CYC(STP_LAT), .SWITCH_CYC(SW_CYC),
    .RETR_CYC(5), .CYC_PER_MS(CPM)) sts_sequencer_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig_in(ext_trig_in), .sweep_active(sweep_active), .step_indicator(step_indicator),
    .manual_sweep_indicator(manual_sweep_indicator), .point_index(point_index),
    .retrace(retrace), .active_param(active_param));
  sts_trig_src sts_trig_src_inst (.ref_clk(ref_clk), .ext_trig_in(ext_trig_in));
  // -----------------------------------------
  // Monitors, timeout and access tasks
  // -----------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    sa_q <= sweep_active;
    if (sweep_active === 1'b1 && sa_q === 1'b0)
      rises <= rises + 1;
    if (sweep_active === 1'b1 && point_index > pmax)
      pmax <= point_index;
    if (cycles == 30000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask
  task automatic wait_lvl(input logic lvl, input int lim);
    n = 0;
    while (sweep_active !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == lim) chk("sweep wait", lvl, ~lvl);
  endtask
  task automatic idle;
    int q;
    n = 0;
    q = 0;
    while (q < 2 && n < 400) begin
      @(posedge ref_clk);
      n++;
      q = ((sweep_active | retrace) === 1'b0) ? q + 1 : 0;
    end
    if (q < 2) chk("idle wait", 32'h0, 32'h1);
  endtask
  task automatic meas(input int lim);
    wait_lvl(1'b1, lim);
    len = 0;
    while (sweep_active === 1'b1 && len < 3000) begin
      @(posedge ref_clk);
      len++;
    end
    if (len == 3000) chk("sweep end", 32'h0, 32'h1);
  endtask
  function automatic int ladder(input int i);
    int m;
    m = (i % 3 == 0) ? 1 : ((i % 3 == 1) ? 2 : 5);
    repeat (i / 3) m = m * 10;
    return m * CPM;
  endfunction
  // -----------------------------------------
  // Main sequence
  // -----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd("time", `STS_TIME_OFS, 32'h3);
    rd("dwell", `STS_DWELL_OFS, 32'h3);
    rd("minidx", `STS_MINIDX_OFS, 32'h0);
    rd("cmd", `STS_CMD_OFS, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, rerr);
    for (int i = 0; i < 6; i++) begin
      wr(`STS_TIME_OFS, i);
      rd("ladder", `STS_SWTIME_OFS, ladder(i));
    end
    wr(`STS_TIME_OFS, 32'h3);
    wr(`STS_MINIDX_OFS, 32'h5);
    rd("time floor", `STS_TIME_OFS, 32'h5);
    rd("dwell floor", `STS_DWELL_OFS, 32'h5);
    wr(`STS_MINIDX_OFS, 32'h2);
    rd("time kept", `STS_TIME_OFS, 32'h3);
    wr(`STS_CTRL_OFS, 32'h10);
    rd("auto time", `STS_TIME_OFS, 32'h2);
    wr(`STS_CTRL_OFS, 32'h0);
    wr(`STS_MINIDX_OFS, 32'h0);
    wr(`STS_TIME_OFS, 32'h3);
    wr(`STS_DWELL_OFS, 32'h3);
    for (int i = 0; i < 5; i++) begin
      wr(`STS_POINTS_OFS, pw[i]);
      rd("points", `STS_POINTS_OFS, pe[i]);
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(`STS_CMD_OFS, 32'h4);
      rd("trig key", `STS_CTRL_OFS, te[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`STS_CMD_OFS, 32'h8);
      rd("mode key", `STS_CTRL_OFS, te[i] << 2);
    end
    wr(`STS_CTRL_OFS, 32'h24);
    rd("step alt", `STS_CTRL_OFS, 32'h20);
    wr(`STS_CTRL_OFS, 32'h05);
    rd("step ext", `STS_CTRL_OFS, 32'h1);
    wr(`STS_CMD_OFS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("act sweep", 32'h1, active_param);
    wr(`STS_CMD_OFS, 32'h2);
    wr(`STS_CTRL_OFS, 32'h04);
    repeat (2) @(posedge ref_clk);
    chk("manual on", 32'h1, manual_sweep_indicator);
    chk("act manual", 32'h3, active_param);
    chk("step off", 32'h0, step_indicator);
    wr(`STS_CMD_OFS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("manual off", 32'h0, manual_sweep_indicator);
    chk("act dwell", 32'h2, active_param);
    chk("step on", 32'h1, step_indicator);
    wr(`STS_CTRL_OFS, 32'h0);
    $display("test keys done");
    wr(`STS_CMD_OFS, 32'h10);
    rd("single key", `STS_CTRL_OFS, 32'h2);
    idle();
    r = rises;
    wr(`STS_CMD_OFS, 32'h20);
    meas(60);
    chk("retrace", 32'h1, retrace);
    chk("sweep len", ladder(3), len);
    idle();
    chk("one sweep", r + 1, rises);
    wr(`STS_CMD_OFS, 32'h20);
    wait_lvl(1'b1, 60);
    wr(`STS_CMD_OFS, 32'h40);
    repeat (2) @(posedge ref_clk);
    chk("abort", 32'h0, sweep_active);
    chk("abort index", 32'h0, {21'h0, point_index});
    $display("test single done");
    wr(`STS_CTRL_OFS, 32'h1);
    idle();
    r = rises;
    repeat (30) @(posedge ref_clk);
    chk("ext waits", r, rises);
    c0 = cycles;
    sts_trig_src_inst.fire(3);
    wait_lvl(1'b1, 60);
    chk("ext latency", 32'h1, (cycles - c0 >= EXT_LAT) && (cycles - c0 <= EXT_LAT + 8));
    idle();
    $display("test external done");
    wr(`STS_CTRL_OFS, 32'h04);
    wr(`STS_POINTS_OFS, 32'h2);
    wr(`STS_DWELL_OFS, 32'h0);
    meas(300);
    pmax = 11'h000;
    meas(300);
    chk("step len", 2 * (ladder(0) + SW_CYC), len);
    chk("last point", 32'h1, {21'h0, pmax});
    wr(`STS_CTRL_OFS, 32'h08);
    wait_lvl(1'b1, 300);
    repeat (40) @(posedge ref_clk);
    chk("step waits", 32'h1, sweep_active);
    p = point_index;
    c0 = cycles;
    sts_trig_src_inst.fire(3);
    n = 0;
    while (point_index === p && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    chk("step latency", 32'h1, (cycles - c0 >= STP_LAT) && (cycles - c0 <= STP_LAT + 8));
    wr(`STS_CMD_OFS, 32'h40);
    $display("test stepped done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
